// [design/ccrb_top.v]
// Control register bank of a 14-bit sampling converter, with output word path.
// Assumes a host on the same clock drives the register strobes; samples arrive
// in offset binary on every clock, the clock being the converter input clock.
//
// How it works
// - Four-bit test selector; nonzero code puts test data on output word.
// - Selector zero, its reset value, passes converted samples through.
// - Code one outputs constant midscale word.
// - Code four alternates complementary checkerboard words each sample.
// - Code five outputs 23-stage pseudo-random sequence, one word per sample.
// - Code six outputs 9-stage pseudo-random sequence, one word per sample.
// - Code seven alternates all-ones and all-zeros words each sample.
// - Code nine outputs a pattern where individual bits toggle.
// - Code twelve outputs mixed bit frequency pattern, bits toggle at different rates.
// - Mode field: 00 run, 01 power-down, 10 standby, 11 digital reset.
// - Each drive strength field is two bits, codes select one to four stripes.
// - Drive strength register resets to 0x22.
`timescale 1ns/1ns
`include "ccrb_defines.vh"

module ccrb_top (
  // Clock and reset
  input  wire        i_clock,
  input  wire        i_reset,
  // Register access
  input  wire        i_reg_wr,
  input  wire        i_reg_rd,
  input  wire [7:0]  i_reg_addr,
  input  wire [7:0]  i_reg_wdata,
  output reg  [7:0]  o_reg_rdata,
  output reg         o_reg_rvalid,
  // Converter core
  input  wire [13:0] i_sample,
  output reg  [13:0] o_data,
  output reg         o_data_en,
  output reg         o_data_oe_n,
  // Chip control
  output reg         o_power_down,
  output reg         o_standby,
  output reg         o_digital_reset,
  output reg         o_self_test_control,
  output reg         o_bist_init,
  output reg  [7:0]  o_offset_trim,
  output reg  [1:0]  o_drive_dco33,
  output reg  [1:0]  o_drive_dco18,
  output reg  [1:0]  o_drive_data33,
  output reg  [1:0]  o_drive_data18
);

  // ----------------------------------------
  // Register storage
  // ----------------------------------------
  reg  [7:0]  mode_r;
  reg  [7:0]  clkdiv_r;
  reg  [7:0]  test_r;
  reg  [7:0]  bist_r;
  reg  [7:0]  offset_r;
  reg  [7:0]  outfmt_r;
  reg  [7:0]  drive_r;
  reg  [7:0]  rdata_nxt;

  // Writes keep only the implemented bits, so open bits read back as zero
  always @(posedge i_clock) begin
    if (i_reset) begin
      mode_r   <= `CCRB_RST_ZERO;
      clkdiv_r <= `CCRB_RST_ZERO;
      test_r   <= `CCRB_RST_ZERO;
      bist_r   <= `CCRB_RST_ZERO;
      offset_r <= `CCRB_RST_ZERO;
      outfmt_r <= `CCRB_RST_ZERO;
      drive_r  <= `CCRB_RST_DRIVE;
    end else if (i_reg_wr) begin
      case (i_reg_addr)
        `CCRB_ADDR_MODE:   mode_r   <= i_reg_wdata & `CCRB_MASK_MODE;
        `CCRB_ADDR_CLKDIV: clkdiv_r <= i_reg_wdata & `CCRB_MASK_CLKDIV;
        `CCRB_ADDR_TEST:   test_r   <= i_reg_wdata & `CCRB_MASK_TEST;
        `CCRB_ADDR_BIST:   bist_r   <= i_reg_wdata & `CCRB_MASK_BIST;
        `CCRB_ADDR_OFFSET: offset_r <= i_reg_wdata & `CCRB_MASK_OFFSET;
        `CCRB_ADDR_OUTFMT: outfmt_r <= i_reg_wdata & `CCRB_MASK_OUTFMT;
        `CCRB_ADDR_DRIVE:  drive_r  <= i_reg_wdata & `CCRB_MASK_DRIVE;
        default: ; // Unmapped writes are dropped
      endcase
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  // Read mux; unmapped offsets answer zero
  always @* begin
    case (i_reg_addr)
      `CCRB_ADDR_MODE:   rdata_nxt = mode_r;
      `CCRB_ADDR_CLKDIV: rdata_nxt = clkdiv_r;
      `CCRB_ADDR_TEST:   rdata_nxt = test_r;
      `CCRB_ADDR_BIST:   rdata_nxt = bist_r;
      `CCRB_ADDR_OFFSET: rdata_nxt = offset_r;
      `CCRB_ADDR_OUTFMT: rdata_nxt = outfmt_r;
      `CCRB_ADDR_DRIVE:  rdata_nxt = drive_r;
      default:           rdata_nxt = `CCRB_RST_ZERO;
    endcase
  end

  // Read data held until the next read
  always @(posedge i_clock) begin
    if (i_reset) begin
      o_reg_rdata  <= `CCRB_RST_ZERO;
      o_reg_rvalid <= 1'b0;
    end else begin
      o_reg_rvalid <= i_reg_rd;
      if (i_reg_rd) begin
        o_reg_rdata <= rdata_nxt;
      end
    end
  end

  // ----------------------------------------
  // Mode decode and clock divider
  // ----------------------------------------
  wire [1:0] mode_sel  = mode_r[1:0];
  wire       dig_reset = (mode_sel == `CCRB_MODE_DRESET);
  reg  [2:0] div_cnt_r;
  reg        tick_r;
  wire       div_last  = (div_cnt_r == clkdiv_r[2:0]);

  // Count to field value, giving one sample per value+1 clocks
  always @(posedge i_clock) begin
    if (i_reset || dig_reset) begin
      div_cnt_r <= 3'h0;
      tick_r    <= 1'b0;
    end else begin
      div_cnt_r <= div_last ? 3'h0 : div_cnt_r + 3'h1;
      tick_r    <= div_last && (mode_sel == `CCRB_MODE_RUN);
    end
  end

  // ----------------------------------------
  // Pattern generators
  // ----------------------------------------
  wire [`CCRB_PN23_LEN-1:0] pn23_state;
  wire [`CCRB_PN9_LEN-1:0]  pn9_state;
  reg                       tog_r;
  reg  [13:0]               cnt_r;
  reg  [13:0]               walk_r;

  // Long sequence, restartable from the test register
  ccrb_prbs #(
    .LEN (`CCRB_PN23_LEN),
    .TAP (`CCRB_PN23_TAP)
  ) u_pn23 (
    .i_clock   (i_clock),
    .i_reset   (i_reset),
    .i_restart (dig_reset | test_r[`CCRB_TEST_PN23_RST]),
    .i_step    (tick_r),
    .o_state   (pn23_state)
  );

  // Short sequence
  ccrb_prbs #(
    .LEN (`CCRB_PN9_LEN),
    .TAP (`CCRB_PN9_TAP)
  ) u_pn9 (
    .i_clock   (i_clock),
    .i_reset   (i_reset),
    .i_restart (dig_reset | test_r[`CCRB_TEST_PN9_RST]),
    .i_step    (tick_r),
    .o_state   (pn9_state)
  );

  // Toggle and counter advance once per sample; walking bit advances every second sample
  always @(posedge i_clock) begin
    if (i_reset || dig_reset) begin
      tog_r  <= 1'b0;
      cnt_r  <= `CCRB_W_ZERO;
      walk_r <= `CCRB_W_ONEHI;
    end else if (tick_r) begin
      tog_r <= ~tog_r;
      cnt_r <= cnt_r + 14'h0001;
      if (tog_r) begin
        walk_r <= {walk_r[12:0], walk_r[13]};
      end
    end
  end

  // ----------------------------------------
  // Output word selection
  // ----------------------------------------
  reg  [13:0] fmt_word;
  reg  [13:0] pat_word;
  wire [3:0]  tp_sel = test_r[3:0];

  // Format applies to converted data only; test words go out raw
  always @* begin
    case (outfmt_r[1:0])
      `CCRB_FMT_TWOS: fmt_word = {~i_sample[13], i_sample[12:0]};
      `CCRB_FMT_GRAY: fmt_word = i_sample ^ {1'b0, i_sample[13:1]};
      default:        fmt_word = i_sample;
    endcase
    if (outfmt_r[`CCRB_OUT_INVERT]) begin
      fmt_word = ~fmt_word;
    end
  end

  // Test word per selector; unsupported codes give zero
  always @* begin
    case (tp_sel)
      `CCRB_TP_MID:   pat_word = `CCRB_W_MID;
      `CCRB_TP_POSFS: pat_word = `CCRB_W_ONES;
      `CCRB_TP_NEGFS: pat_word = `CCRB_W_ZERO;
      `CCRB_TP_CHECK: pat_word = tog_r ? `CCRB_W_CHK_B : `CCRB_W_CHK_A;
      `CCRB_TP_PN23:  pat_word = pn23_state[`CCRB_PN23_LEN-1 -: 14];
      `CCRB_TP_PN9:   pat_word = {pn9_state, 5'h00};
      `CCRB_TP_WTOG:  pat_word = tog_r ? `CCRB_W_ZERO : `CCRB_W_ONES;
      `CCRB_TP_BTOG:  pat_word = tog_r ? `CCRB_W_ZERO : walk_r;
      `CCRB_TP_ONEHI: pat_word = `CCRB_W_ONEHI;
      `CCRB_TP_MIXED: pat_word = cnt_r;
      default:        pat_word = `CCRB_W_ZERO;
    endcase
  end

  // Output word captured once per divided sample
  always @(posedge i_clock) begin
    if (i_reset || dig_reset) begin
      o_data    <= `CCRB_W_ZERO;
      o_data_en <= 1'b0;
    end else begin
      o_data_en <= tick_r;
      if (tick_r) begin
        o_data <= (tp_sel == `CCRB_TP_OFF) ? fmt_word : pat_word;
      end
    end
  end

  // ----------------------------------------
  // Control outputs
  // ----------------------------------------
  // Registered so every output leaves a flip-flop
  always @(posedge i_clock) begin
    if (i_reset) begin
      o_data_oe_n     <= 1'b0;
      o_power_down    <= 1'b0;
      o_standby       <= 1'b0;
      o_digital_reset <= 1'b0;
      o_self_test_control   <= 1'b0;
      o_bist_init     <= 1'b0;
      o_offset_trim   <= `CCRB_RST_ZERO;
      o_drive_dco33   <= 2'h0;
      o_drive_dco18   <= 2'h0;
      o_drive_data33  <= 2'h0;
      o_drive_data18  <= 2'h0;
    end else begin
      o_data_oe_n     <= outfmt_r[`CCRB_OUT_DISABLE] | (mode_sel == `CCRB_MODE_PDOWN);
      o_power_down    <= (mode_sel == `CCRB_MODE_PDOWN);
      o_standby       <= (mode_sel == `CCRB_MODE_STBY);
      o_digital_reset <= dig_reset;
      o_self_test_control   <= bist_r[`CCRB_BIST_EN];
      o_bist_init     <= bist_r[`CCRB_BIST_INIT];
      o_offset_trim   <= offset_r;
      o_drive_dco33   <= drive_r[7:6];
      o_drive_dco18   <= drive_r[5:4];
      o_drive_data33  <= drive_r[3:2];
      o_drive_data18  <= drive_r[1:0];
    end
  end

endmodule // ccrb_top

// [design/ccrb_defines.vh]
// Constants for the converter control register bank.
// Assumes it is included by its bare name from design files only.
`ifndef CCRB_DEFINES_VH
`define CCRB_DEFINES_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define CCRB_ADDR_MODE     8'h08
`define CCRB_ADDR_CLKDIV   8'h0B
`define CCRB_ADDR_TEST     8'h0D
`define CCRB_ADDR_BIST     8'h0E
`define CCRB_ADDR_OFFSET   8'h10
`define CCRB_ADDR_OUTFMT   8'h14
`define CCRB_ADDR_DRIVE    8'h15

// ----------------------------------------
// Reset values and writable-bit masks
// ----------------------------------------
`define CCRB_RST_ZERO      8'h00
`define CCRB_RST_DRIVE     8'h22
`define CCRB_MASK_MODE     8'hE3
`define CCRB_MASK_CLKDIV   8'h07
`define CCRB_MASK_TEST     8'h3F
`define CCRB_MASK_BIST     8'h05
`define CCRB_MASK_OFFSET   8'hFF
`define CCRB_MASK_OUTFMT   8'hD7
`define CCRB_MASK_DRIVE    8'hFF

// ----------------------------------------
// Operating modes
// ----------------------------------------
`define CCRB_MODE_RUN      2'h0
`define CCRB_MODE_PDOWN    2'h1
`define CCRB_MODE_STBY     2'h2
`define CCRB_MODE_DRESET   2'h3

// ----------------------------------------
// Output formats
// ----------------------------------------
`define CCRB_FMT_TWOS      2'h1
`define CCRB_FMT_GRAY      2'h2

// ----------------------------------------
// Test selector codes
// ----------------------------------------
`define CCRB_TP_OFF        4'h0
`define CCRB_TP_MID        4'h1
`define CCRB_TP_POSFS      4'h2
`define CCRB_TP_NEGFS      4'h3
`define CCRB_TP_CHECK      4'h4
`define CCRB_TP_PN23       4'h5
`define CCRB_TP_PN9        4'h6
`define CCRB_TP_WTOG       4'h7
`define CCRB_TP_BTOG       4'h9
`define CCRB_TP_ONEHI      4'hB
`define CCRB_TP_MIXED      4'hC

// ----------------------------------------
// Pattern words (14 bit)
// ----------------------------------------
`define CCRB_W_MID         14'h2000
`define CCRB_W_ONES        14'h3FFF
`define CCRB_W_ZERO        14'h0000
`define CCRB_W_CHK_A       14'h2AAA
`define CCRB_W_CHK_B       14'h1555
`define CCRB_W_ONEHI       14'h0001

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CCRB_TEST_PN23_RST 5
`define CCRB_TEST_PN9_RST  4
`define CCRB_BIST_EN       0
`define CCRB_BIST_INIT     2
`define CCRB_OUT_DISABLE   4
`define CCRB_OUT_INVERT    2

// ----------------------------------------
// Generator taps
// ----------------------------------------
`define CCRB_PN23_LEN      23
`define CCRB_PN23_TAP      18
`define CCRB_PN9_LEN       9
`define CCRB_PN9_TAP       5

`endif

// [design/ccrb_prbs.v]
// Fibonacci shift-register pseudo-random generator, advanced by a step enable.
// Assumes step and restart come from logic on the same clock.
`timescale 1ns/1ns

module ccrb_prbs #(
  parameter LEN = 9,
  parameter TAP = 5
) (
  // Clock and reset
  input  wire           i_clock,
  input  wire           i_reset,
  // Control
  input  wire           i_restart,
  input  wire           i_step,
  // State
  output reg  [LEN-1:0] o_state
);

  // ----------------------------------------
  // Shift register
  // ----------------------------------------
  // All-ones seed, since the all-zeros state would lock up
  always @(posedge i_clock) begin
    if (i_reset || i_restart) begin
      o_state <= {LEN{1'b1}};
    end else if (i_step) begin
      o_state <= {o_state[LEN-2:0], o_state[LEN-1] ^ o_state[TAP-1]};
    end
  end

endmodule // ccrb_prbs

// [tb/ccrb_host.sv]
// Host model that drives the register strobes of the control register bank.
// Assumes the bank takes strobes on the rising edge and answers reads one edge later.
`timescale 1ns/1ns

module ccrb_host (
  // Clock
  input  wire logic       i_clock,
  // Strobes toward the bank
  output logic            o_reg_wr,
  output logic            o_reg_rd,
  output logic [7:0]      o_reg_addr,
  output logic [7:0]      o_reg_wdata,
  // Read answer
  input  wire logic [7:0] i_reg_rdata,
  input  wire logic       i_reg_rvalid
);
  // Idle values at time zero
  initial begin
    o_reg_wr = 1'b0;
    o_reg_rd = 1'b0;
    o_reg_addr = 8'h00;
    o_reg_wdata = 8'h00;
  end

  // One-cycle write; idle lines show the inverse so stale values never help
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clock);
    o_reg_wr <= 1'b1;
    o_reg_addr <= a;
    o_reg_wdata <= d;
    @(negedge i_clock);
    o_reg_wr <= 1'b0;
    o_reg_addr <= ~a;
    o_reg_wdata <= ~d;
  endtask

  // One-cycle read; the answer stands one cycle, so it is taken in that cycle,
  // before the strobe drops, since the flag is gone after the following edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    @(negedge i_clock);
    o_reg_rd <= 1'b1;
    o_reg_addr <= a;
    @(negedge i_clock);
    d = i_reg_rdata;
    ok = i_reg_rvalid;
    o_reg_rd <= 1'b0;
    o_reg_addr <= ~a;
  endtask
endmodule // ccrb_host

// [tb/ccrb_top_asserts.sv]
// Checker for the control register bank, bound to its top module.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ns

module ccrb_top_asserts (
  input wire logic        i_clock,
  input wire logic        i_reset,
  input wire logic        i_reg_wr,
  input wire logic        i_reg_rd,
  input wire logic [7:0]  i_reg_addr,
  input wire logic [7:0]  i_reg_wdata,
  input wire logic        o_reg_rvalid,
  input wire logic [13:0] o_data,
  input wire logic        o_data_en,
  input wire logic        o_data_oe_n,
  input wire logic        o_power_down,
  input wire logic        o_standby,
  input wire logic        o_digital_reset,
  input wire logic [1:0]  o_drive_dco33,
  input wire logic [1:0]  o_drive_dco18,
  input wire logic [1:0]  o_drive_data33,
  input wire logic [1:0]  o_drive_data18
);
  logic [2:0] div_r;
  logic [3:0] tp_r;
  logic [3:0] age_r;
  wire        run = !o_power_down && !o_standby && !o_digital_reset;

  // Shadow of divider and selector; age lets write transients settle first
  always_ff @(posedge i_clock) begin
    if (i_reset || i_reg_wr) begin
      age_r <= 4'h0;
    end else if (age_r != 4'hF) begin
      age_r <= age_r + 4'h1;
    end
    if (i_reset) begin
      div_r <= 3'h0;
      tp_r <= 4'h0;
    end else if (i_reg_wr && i_reg_addr == 8'h0B) begin
      div_r <= i_reg_wdata[2:0];
    end else if (i_reg_wr && i_reg_addr == 8'h0D) begin
      tp_r <= i_reg_wdata[3:0];
    end
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_reset);

  sequence s_gap1; !o_data_en ##1 o_data_en; endsequence
  sequence s_quiet; age_r == 4'hF && run && o_data_en; endsequence

  property p_rvalid; i_reg_rd |=> o_reg_rvalid; endproperty
  a_rvalid: assert property (p_rvalid) else $error("read answer missing");
  property p_rvpulse; !i_reg_rd |=> !o_reg_rvalid; endproperty
  a_rvpulse: assert property (p_rvpulse) else $error("read answer without read");
  property p_drive; $fell(i_reset) |=> o_drive_dco18 == 2'h2 && o_drive_data18 == 2'h2
    && o_drive_dco33 == 2'h0 && o_drive_data33 == 2'h0; endproperty
  a_drive: assert property (p_drive) else $error("drive default wrong");
  property p_mode; $onehot0({o_power_down, o_standby, o_digital_reset}); endproperty
  a_mode: assert property (p_mode) else $error("two modes at once");
  property p_pd; i_reg_wr && i_reg_addr == 8'h08 && i_reg_wdata[1:0] == 2'h1
    |-> ##[1:3] o_power_down; endproperty
  a_pd: assert property (p_pd) else $error("power-down late");
  property p_oe; o_power_down |-> o_data_oe_n; endproperty
  a_oe: assert property (p_oe) else $error("drivers on in power-down");
  property p_hold; o_standby [*3] |-> !o_data_en; endproperty
  a_hold: assert property (p_hold) else $error("word in standby");
  property p_dres; o_digital_reset [*2] |-> o_data == 14'h0000 && !o_data_en; endproperty
  a_dres: assert property (p_dres) else $error("data kept in reset");
  property p_div; s_quiet ##0 div_r == 3'h1 |=> s_gap1; endproperty
  a_div: assert property (p_div) else $error("divide-by-two spacing");
  property p_mid; s_quiet ##0 tp_r == 4'h1 |-> o_data == 14'h2000; endproperty
  a_mid: assert property (p_mid) else $error("midscale word wrong");
  property p_alt; s_quiet ##0 $past(o_data_en) && (tp_r == 4'h4 || tp_r == 4'h7)
    |-> o_data == ~$past(o_data); endproperty
  a_alt: assert property (p_alt) else $error("words not complementary");
endmodule // ccrb_top_asserts

bind ccrb_top ccrb_top_asserts ccrb_top_asserts_i (.i_clock, .i_reset, .i_reg_wr,
  .i_reg_rd, .i_reg_addr, .i_reg_wdata, .o_reg_rvalid, .o_data, .o_data_en, .o_data_oe_n,
  .o_power_down, .o_standby, .o_digital_reset, .o_drive_dco33, .o_drive_dco18,
  .o_drive_data33, .o_drive_data18);

// [tb/tb.sv]
// Testbench for the control register bank: registers, patterns, modes, divider.
// Assumes the host model drives strobes and the bench drives samples on falling edges.
`timescale 1ns/1ns

module tb;
  logic        i_clock = 1'b0;
  logic        i_reset = 1'b1;
  logic [13:0] smp = 14'h0000;
  logic        wr, rd, rvalid, en, oe_n, pd, sb, dr, be, bi;
  logic [7:0]  addr, wdata, rdata, trim;
  logic [13:0] dat;
  logic [1:0]  d33, d18, q33, q18;
  int          num_errors = 0;
  int          samples_checked = 0;
  logic [7:0]  ra [7] = '{8'h08, 8'h0B, 8'h0D, 8'h0E, 8'h10, 8'h14, 8'h15};
  logic [7:0]  rm [7] = '{8'hE3, 8'h07, 8'h3F, 8'h05, 8'hFF, 8'hD7, 8'hFF};
  logic [3:0]  tc [5] = '{4'h1, 4'h2, 4'h3, 4'hB, 4'hF};
  logic [13:0] te [5] = '{14'h2000, 14'h3FFF, 14'h0000, 14'h0001, 14'h0000};
  logic [3:0]  sq [6] = '{4'h4, 4'h7, 4'h5, 4'h6, 4'h9, 4'hC};
  logic [13:0] me [4] = '{14'h00, 14'h12, 14'h08, 14'h04};
  int          dv [4] = '{0, 1, 3, 7};

  always #5 i_clock = ~i_clock;

  ccrb_host ccrb_host_i (.i_clock(i_clock), .o_reg_wr(wr), .o_reg_rd(rd), .o_reg_addr(addr),
    .o_reg_wdata(wdata), .i_reg_rdata(rdata), .i_reg_rvalid(rvalid));
  ccrb_top ccrb_top_i (.i_clock(i_clock), .i_reset(i_reset), .i_reg_wr(wr), .i_reg_rd(rd),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
    .i_sample(smp), .o_data(dat), .o_data_en(en), .o_data_oe_n(oe_n), .o_power_down(pd),
    .o_standby(sb), .o_digital_reset(dr), .o_self_test_control(be), .o_bist_init(bi),
    .o_offset_trim(trim), .o_drive_dco33(q33), .o_drive_dco18(q18), .o_drive_data33(d33),
    .o_drive_data18(d18));

  task automatic cyc(input int n);
    repeat (n) @(negedge i_clock);
  endtask

  task automatic chk(input logic [13:0] got, input logic [13:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Read with answer check; the answer flag must stand in its one cycle
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    logic ok;
    ccrb_host_i.rd(a, v, ok);
    chk(14'({ok, v}), 14'({1'b1, e}));
  endtask

  // Reset values, writable masks, unmapped place, drive fields
  task automatic t_regs();
    for (int k = 0; k < 7; k++) begin
      rdc(ra[k], (k == 6) ? 8'h22 : 8'h00);
      ccrb_host_i.wr(ra[k], 8'hFF);
      rdc(ra[k], rm[k]);
      ccrb_host_i.wr(ra[k], (k == 6) ? 8'hE4 : 8'h00);
    end
    ccrb_host_i.wr(8'h20, 8'h5A);
    rdc(8'h20, 8'h00);
    cyc(2);
    chk({6'h00, q33, q18, d33, d18}, 14'h00E4);
  endtask

  // Every format code with and without invert on live samples
  task automatic t_fmt();
    logic [13:0] e;
    smp = 14'h2C5A;
    for (int k = 0; k < 8; k++) begin
      ccrb_host_i.wr(8'h14, 8'(k));
      e = (k[1:0] == 2'h1) ? smp ^ 14'h2000 : (k[1:0] == 2'h2) ? smp ^ (smp >> 1) : smp;
      e = k[2] ? ~e : e;
      cyc(6);
      chk(dat, e);
    end
    ccrb_host_i.wr(8'h14, 8'h00);
  endtask

  // Constant, held-seed and sequential test words
  task automatic t_pat();
    logic [13:0] p;
    for (int k = 0; k < 5; k++) begin
      ccrb_host_i.wr(8'h0D, {4'h0, tc[k]});
      cyc(16);
      chk(dat, te[k]);
    end
    ccrb_host_i.wr(8'h0D, 8'h25);
    cyc(16);
    chk(dat, 14'h3FFF);
    ccrb_host_i.wr(8'h0D, 8'h16);
    cyc(16);
    chk(dat, 14'h3FE0);
    for (int k = 0; k < 6; k++) begin
      ccrb_host_i.wr(8'h0D, {4'h0, sq[k]});
      cyc(16);
      repeat (4) begin
        p = dat;
        cyc(1);
        case (sq[k])
          4'h4: chk(dat, (p == 14'h2AAA) ? 14'h1555 : 14'h2AAA);
          4'h7: chk(dat, (p == 14'h3FFF) ? 14'h0000 : 14'h3FFF);
          4'h5: chk({dat[13:1], 1'b0}, {p[12:0], 1'b0});
          4'h6: chk(dat, {p[12:5], p[13] ^ p[9], 5'h00});
          4'h9: chk(14'((p == 14'h0000) ? $onehot(dat) : (dat == 14'h0000)), 14'h1);
          default: chk(dat, p + 14'h0001);
        endcase
      end
    end
    ccrb_host_i.wr(8'h0D, 8'h00);
  endtask

  // Each non-run mode, then output disable while running
  task automatic t_mode();
    for (int m = 1; m < 4; m++) begin
      ccrb_host_i.wr(8'h08, 8'(m));
      cyc(4);
      chk(14'({pd, sb, dr, oe_n, en}), me[m]);
    end
    chk(dat, 14'h0000);
    ccrb_host_i.wr(8'h08, 8'h00);
    ccrb_host_i.wr(8'h14, 8'h10);
    cyc(4);
    chk(14'({pd, oe_n, en}), 14'h3);
    ccrb_host_i.wr(8'h14, 8'h00);
  endtask

  // Word rate over a fixed window for divider settings 0, 1, 3 and 7
  task automatic t_div();
    int n;
    for (int k = 0; k < 4; k++) begin
      ccrb_host_i.wr(8'h0B, 8'(dv[k]));
      cyc(16);
      n = 0;
      repeat (24) begin
        cyc(1);
        n += int'(en);
      end
      chk(14'(n), 14'(24 / (dv[k] + 1)));
    end
    ccrb_host_i.wr(8'h0B, 8'h00);
  endtask

  // Self-test levels and offset trim
  task automatic t_bist();
    ccrb_host_i.wr(8'h0E, 8'h05);
    ccrb_host_i.wr(8'h10, 8'hA5);
    cyc(3);
    chk({4'h0, be, bi, trim}, 14'h03A5);
    ccrb_host_i.wr(8'h0E, 8'h00);
    cyc(3);
    chk(14'({be, bi}), 14'h0);
  endtask

  task automatic finish_test();
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    cyc(16);
    i_reset = 1'b0;
    t_regs();
    t_fmt();
    t_pat();
    t_mode();
    t_div();
    t_bist();
    finish_test();
  end
endmodule // tb
